// ### osc_ctrl.sv
// Purpose: Oscillator enables, stable flags, system clock switching, crystal
//          monitor, clock output and deep-sleep voltage key protection.
// Assumes: Oscillator clocks arrive as levels synchronous to clk_in.
// Notes:   Avalon-MM slave, every access answers one cycle after it starts.
//
// Decided for this implementation: the Avalon-MM register port.
`timescale 1ns/100ps
module osc_ctrl #(
  parameter int CKM_TIMEOUT = osc_pkg::CKM_TIMEOUT_CYC
) (
  input  wire logic        clk_in,
  input  wire logic        reset_n_in,
  input  wire logic [4:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic [31:0]      avs_readdata_out,
  output logic             avs_waitrequest_out,
  input  wire logic        rc8_ready_in,
  input  wire logic        hx_ready_in,
  input  wire logic        pll_lock_in,
  input  wire logic        rc48_ready_in,
  input  wire logic        lx_ready_in,
  input  wire logic        rc40_ready_in,
  input  wire logic [1:0]  pll_src_in,
  input  wire logic        clk_rc28_in,
  input  wire logic        clk_rc40_in,
  input  wire logic        clk_lx_osc_in,
  input  wire logic        clk_lx_pin_in,
  input  wire logic        clk_rc8_in,
  input  wire logic        clk_hx_in,
  input  wire logic        clk_pll_in,
  input  wire logic        clk_sys_in,
  input  wire logic        deep_sleep_in,
  input  wire logic        standby_in,
  input  wire logic        cec_lx_sel_in,
  input  wire logic        usart_lx_sel_in,
  input  wire logic        cec_wake_in,
  input  wire logic        usart_wake_in,
  input  wire logic        cec_rc8_req_in,
  input  wire logic        usart_rc8_req_in,
  output logic             rc8_on_out,
  output logic             hx_on_out,
  output logic             hx_bypass_out,
  output logic             pll_on_out,
  output logic             rc48_on_out,
  output logic             lx_on_out,
  output logic             rc40_on_out,
  output logic             lx_clk_out,
  output logic [1:0]       sysclk_sel_out,
  output logic             clock_output_out,
  output logic             stb_irq_out,
  output logic             nmi_out,
  output logic             wake_out,
  output logic [1:0]       dsv_out
);

  // Elaboration check: the stuck counter is 16 bits and needs two cycles.
  if (CKM_TIMEOUT < 2 || CKM_TIMEOUT > 65535) begin : g_bad_timeout
    $error("CKM_TIMEOUT out of range");
  end

  localparam logic [15:0] CKM_LIM = 16'(CKM_TIMEOUT);

  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
    logic        rc8en;
    logic        hen;
    logic        hbps;
    logic        mon_en;
    logic        pll_on;
    logic        rc48en;
    logic        rc48ie;
    logic        rc48f;
    logic        lxen;
    logic        lxbps;
    logic        lxie;
    logic        lxf;
    logic        rc40en;
    logic        rc40ie;
    logic        rc40f;
    logic        mon_flag;
    logic        nmi;
    logic [1:0]  sw_req;
    logic [1:0]  scss;
    logic        pll_full;
    logic [2:0]  codiv;
    logic [2:0]  cosel;
    logic [1:0]  dsv;
    logic        unlock;
    logic        sleep_d;
    logic [2:0]  stb_d;
    logic        hx_d;
    logic [15:0] stuck;
    logic        src_d;
    logic [6:0]  div_cnt;
    logic        pll_d;
    logic        pll_half;
    logic        ckout;
  } osc_state_t;

  osc_state_t st_reg;
  osc_state_t st_next;

  // Stable flags follow enable and the oscillator's own ready indication.
  logic rc8_stb;
  logic hx_stb;
  logic pll_stb;
  logic rc48_stb;
  logic lx_stb;
  logic rc40_stb;
  logic in_sleep;
  logic rc8_run;
  logic lx_clk;
  logic sel_src;
  logic [31:0] wmask;
  logic [31:0] wd;
  logic wr;
  logic rd;

  assign in_sleep = deep_sleep_in | standby_in;
  // Monitor or a wake peripheral in deep-sleep keeps the 8 MHz RC alive.
  assign rc8_run  = st_reg.rc8en | st_reg.mon_en
                  | (deep_sleep_in & (cec_rc8_req_in | usart_rc8_req_in));
  assign rc8_stb  = rc8_run & rc8_ready_in;
  assign hx_stb   = st_reg.hen & hx_ready_in;
  assign pll_stb  = st_reg.pll_on & pll_lock_in;
  assign rc48_stb = st_reg.rc48en & rc48_ready_in;
  assign lx_stb   = st_reg.lxen & lx_ready_in;
  assign rc40_stb = st_reg.rc40en & rc40_ready_in;
  // Bypass with enable routes the external pin clock straight through.
  assign lx_clk   = st_reg.lxen & (st_reg.lxbps ? clk_lx_pin_in : clk_lx_osc_in);
  assign rd       = avs_read_in & ~avs_write_in;
  assign wr       = avs_write_in & ~avs_read_in;
  assign wd       = avs_writedata_in;
  assign wmask    = {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}},
                     {8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};

  // Clock output source mux.
  always_comb begin
    unique case (st_reg.cosel)
      osc_pkg::CO_RC28: sel_src = clk_rc28_in;
      osc_pkg::CO_RC40: sel_src = clk_rc40_in;
      osc_pkg::CO_LX:   sel_src = lx_clk;
      osc_pkg::CO_SYS:  sel_src = clk_sys_in;
      osc_pkg::CO_RC8:  sel_src = clk_rc8_in;
      osc_pkg::CO_HX:   sel_src = clk_hx_in;
      osc_pkg::CO_PLL:  sel_src = st_reg.pll_full ? clk_pll_in : st_reg.pll_half;
      default:          sel_src = 1'b0;
    endcase
  end

  // Next-state logic for bus, oscillators, switching, monitor and output.
  always_comb begin
    logic        go;
    logic        hx_used;
    logic        fail;
    logic        tgt_ok;
    logic [31:0] m;
    go      = 1'b0;
    hx_used = 1'b0;
    fail    = 1'b0;
    tgt_ok  = 1'b0;
    m       = 32'h0000_0000;
    st_next = st_reg;
    st_next.nmi = 1'b0;
    // A request is taken on the cycle before its acknowledge is high.
    st_next.ack = (rd | wr) & ~st_reg.ack;
    go = (rd | wr) & ~st_reg.ack;
    m  = wd & wmask;
    if (go && wr) begin
      unique case (avs_address_in)
        osc_pkg::CTL0_OFS: begin
          if (avs_byteenable_in[0]) begin
            // Clearing the 8 MHz RC is refused while it feeds the system or PLL.
            if (m[osc_pkg::RC8EN] || !(st_reg.scss == osc_pkg::SW_RC8 ||
                (st_reg.pll_on && pll_src_in == osc_pkg::PS_RC8))) begin
              st_next.rc8en = m[osc_pkg::RC8EN];
            end
          end
          if (avs_byteenable_in[2]) begin
            if (m[osc_pkg::HEN] || !(st_reg.scss == osc_pkg::SW_HX ||
                (st_reg.pll_on && pll_src_in == osc_pkg::PS_HX))) begin
              st_next.hen = m[osc_pkg::HEN];
            end
            if (!st_reg.hen) begin
              st_next.hbps = m[osc_pkg::HBPS];
            end
            st_next.mon_en = m[osc_pkg::MON_EN];
          end
          if (avs_byteenable_in[3]) begin
            if (m[osc_pkg::PLL_ON] || st_reg.scss != osc_pkg::SW_PLL) begin
              st_next.pll_on = m[osc_pkg::PLL_ON];
            end
          end
        end
        osc_pkg::CFG0_OFS: begin
          if (avs_byteenable_in[0]) begin
            st_next.sw_req = m[osc_pkg::SW_REQ +: 2];
          end
          if (avs_byteenable_in[3]) begin
            st_next.cosel = m[osc_pkg::COSEL +: 3];
            st_next.codiv = m[osc_pkg::CODIV +: 3];
            st_next.pll_full = m[osc_pkg::PLL_FULL];
          end
        end
        osc_pkg::INT_OFS: begin
          if (avs_byteenable_in[1]) begin
            st_next.rc40ie = m[osc_pkg::RC40IE];
            st_next.lxie   = m[osc_pkg::LXIE];
          end
          if (m[osc_pkg::CLR + osc_pkg::RC40F]) st_next.rc40f = 1'b0;
          if (m[osc_pkg::CLR + osc_pkg::LXF])   st_next.lxf   = 1'b0;
          if (m[osc_pkg::CLR + osc_pkg::RC48F]) st_next.rc48f = 1'b0;
          if (m[osc_pkg::CLR + osc_pkg::CKMF])  st_next.mon_flag = 1'b0;
        end
        osc_pkg::BDCTL_OFS: begin
          if (avs_byteenable_in[0]) begin
            st_next.lxen  = m[osc_pkg::EN];
            st_next.lxbps = m[osc_pkg::OPT];
          end
        end
        osc_pkg::RSTSCK_OFS: begin
          if (avs_byteenable_in[0]) begin
            st_next.rc40en = m[osc_pkg::EN];
          end
        end
        osc_pkg::ADDCTL_OFS: begin
          if (avs_byteenable_in[0]) begin
            if (m[osc_pkg::EN] || !(st_reg.pll_on && pll_src_in == osc_pkg::PS_RC48)) begin
              st_next.rc48en = m[osc_pkg::EN];
            end
            st_next.rc48ie = m[osc_pkg::OPT];
          end
        end
        osc_pkg::DSV_OFS: begin
          // A write is taken only while unlocked, and it uses up the key.
          if (st_reg.unlock && avs_byteenable_in[0]) begin
            st_next.dsv = m[1:0];
          end
          st_next.unlock = 1'b0;
        end
        osc_pkg::VKEY_OFS: begin
          st_next.unlock = (wd == osc_pkg::VKEY_VAL) && (avs_byteenable_in == 4'hF);
        end
        default: begin
        end
      endcase
    end
    // Read data, registered with the acknowledge.
    st_next.rdata = 32'h0000_0000;
    if (go && rd) begin
      unique case (avs_address_in)
        osc_pkg::CTL0_OFS: begin
          st_next.rdata[osc_pkg::RC8EN]  = st_reg.rc8en;
          st_next.rdata[osc_pkg::RC8STB] = rc8_stb;
          st_next.rdata[osc_pkg::HEN]    = st_reg.hen;
          st_next.rdata[osc_pkg::HSTB]   = hx_stb;
          st_next.rdata[osc_pkg::HBPS]   = st_reg.hbps;
          st_next.rdata[osc_pkg::MON_EN]  = st_reg.mon_en;
          st_next.rdata[osc_pkg::PLL_ON]  = st_reg.pll_on;
          st_next.rdata[osc_pkg::PLL_RDY] = pll_stb;
        end
        osc_pkg::CFG0_OFS: begin
          st_next.rdata[osc_pkg::SW_REQ +: 2] = st_reg.sw_req;
          st_next.rdata[osc_pkg::SCSS +: 2]  = st_reg.scss;
          st_next.rdata[osc_pkg::COSEL +: 3] = st_reg.cosel;
          st_next.rdata[osc_pkg::CODIV +: 3] = st_reg.codiv;
          st_next.rdata[osc_pkg::PLL_FULL]   = st_reg.pll_full;
        end
        osc_pkg::INT_OFS: begin
          st_next.rdata[osc_pkg::RC40F]  = st_reg.rc40f;
          st_next.rdata[osc_pkg::LXF]    = st_reg.lxf;
          st_next.rdata[osc_pkg::RC48F]  = st_reg.rc48f;
          st_next.rdata[osc_pkg::CKMF]   = st_reg.mon_flag;
          st_next.rdata[osc_pkg::RC40IE] = st_reg.rc40ie;
          st_next.rdata[osc_pkg::LXIE]   = st_reg.lxie;
        end
        osc_pkg::BDCTL_OFS: begin
          st_next.rdata[2:0] = {st_reg.lxbps, lx_stb, st_reg.lxen};
        end
        osc_pkg::RSTSCK_OFS: begin
          st_next.rdata[1:0] = {rc40_stb, st_reg.rc40en};
        end
        osc_pkg::ADDCTL_OFS: begin
          st_next.rdata[2:0] = {st_reg.rc48ie, rc48_stb, st_reg.rc48en};
        end
        osc_pkg::DSV_OFS: begin
          st_next.rdata[1:0] = st_reg.dsv;
        end
        default: begin
        end
      endcase
    end
    // Sticky stable flags: a new rising stable wins over a clear.
    st_next.stb_d = {rc48_stb, lx_stb, rc40_stb};
    if (rc48_stb && !st_reg.stb_d[2]) st_next.rc48f = 1'b1;
    if (lx_stb && !st_reg.stb_d[1])   st_next.lxf   = 1'b1;
    if (rc40_stb && !st_reg.stb_d[0]) st_next.rc40f = 1'b1;
    // Crystal monitor: count cycles without a crystal edge.
    st_next.hx_d = clk_hx_in;
    if (!st_reg.mon_en || !hx_stb || clk_hx_in != st_reg.hx_d) begin
      st_next.stuck = 16'h0000;
    end else if (st_reg.stuck != CKM_LIM) begin
      st_next.stuck = st_reg.stuck + 16'h0001;
    end
    fail    = st_reg.mon_en && hx_stb && st_reg.stuck == CKM_LIM;
    hx_used = st_reg.scss == osc_pkg::SW_HX ||
              (st_reg.pll_on && pll_src_in == osc_pkg::PS_HX);
    if (fail) begin
      st_next.hen      = 1'b0;
      st_next.mon_flag = 1'b1;
      st_next.nmi      = 1'b1;
      st_next.rc8en    = 1'b1;
      if (hx_used) begin
        st_next.scss   = osc_pkg::SW_RC8;
        st_next.pll_on = 1'b0;
      end
    end else begin
      // Switch only once the target is stable; a stuck crystal holds RC8.
      // A crystal or PLL target being switched off in this same cycle is not taken.
      unique case (st_reg.sw_req)
        osc_pkg::SW_RC8: tgt_ok = rc8_stb;
        osc_pkg::SW_HX:  tgt_ok = hx_stb && st_next.hen && !st_reg.mon_flag;
        osc_pkg::SW_PLL: tgt_ok = pll_stb && st_next.pll_on &&
                                  !(st_reg.mon_flag && pll_src_in == osc_pkg::PS_HX);
        default:         tgt_ok = 1'b0;
      endcase
      if (tgt_ok) begin
        st_next.scss = st_reg.sw_req;
      end
    end
    // Entering deep-sleep or standby stops crystal and PLL; leaving wakes RC8.
    st_next.sleep_d = in_sleep;
    if (in_sleep && !st_reg.sleep_d) begin
      st_next.pll_on = 1'b0;
      st_next.hen    = 1'b0;
      st_next.scss   = osc_pkg::SW_RC8;
      st_next.sw_req = osc_pkg::SW_RC8;
    end else if (!in_sleep && st_reg.sleep_d) begin
      st_next.rc8en = 1'b1;
    end
    // Output divider counts rising edges of the selected source.
    st_next.pll_d = clk_pll_in;
    if (clk_pll_in && !st_reg.pll_d) begin
      st_next.pll_half = ~st_reg.pll_half;
    end
    st_next.src_d = sel_src;
    if (sel_src && !st_reg.src_d) begin
      st_next.div_cnt = st_reg.div_cnt + 7'h01;
    end
    if (st_reg.cosel == 3'h0) begin
      st_next.ckout = 1'b0;
    end else if (st_reg.codiv == 3'h0) begin
      st_next.ckout = sel_src;
    end else begin
      st_next.ckout = st_reg.div_cnt[st_reg.codiv - 3'h1];
    end
  end

  // State register.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_reg       <= '0;
      st_reg.rc8en <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs.
  assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~st_reg.ack;
  assign avs_readdata_out    = st_reg.rdata;
  assign rc8_on_out          = rc8_run;
  assign hx_on_out           = st_reg.hen;
  assign hx_bypass_out       = st_reg.hbps;
  assign pll_on_out          = st_reg.pll_on;
  assign rc48_on_out         = st_reg.rc48en;
  assign lx_on_out           = st_reg.lxen;
  assign rc40_on_out         = st_reg.rc40en;
  assign lx_clk_out          = lx_clk;
  assign sysclk_sel_out      = st_reg.scss;
  assign clock_output_out    = st_reg.ckout;
  assign nmi_out             = st_reg.nmi;
  assign dsv_out             = st_reg.dsv;
  assign stb_irq_out = (st_reg.rc48f & st_reg.rc48ie) | (st_reg.lxf & st_reg.lxie)
                     | (st_reg.rc40f & st_reg.rc40ie);
  // Wake only from peripherals clocked by an enabled low crystal.
  assign wake_out = deep_sleep_in & st_reg.lxen
                  & ((cec_wake_in & cec_lx_sel_in) | (usart_wake_in & usart_lx_sel_in));

endmodule

// ### osc_pkg.sv
// Purpose: Shared constants for the oscillator and system clock control block.
// Assumes: Registers are 32-bit words at byte addresses on an Avalon-MM slave.
// Notes:   Field positions are bit indexes inside each register word.
package osc_pkg;
  // Register byte offsets.
  localparam logic [4:0] CTL0_OFS   = 5'h00;
  localparam logic [4:0] CFG0_OFS   = 5'h04;
  localparam logic [4:0] INT_OFS    = 5'h08;
  localparam logic [4:0] BDCTL_OFS  = 5'h0C;
  localparam logic [4:0] RSTSCK_OFS = 5'h10;
  localparam logic [4:0] ADDCTL_OFS = 5'h14;
  localparam logic [4:0] DSV_OFS    = 5'h18;
  localparam logic [4:0] VKEY_OFS   = 5'h1C;
  // Control register zero fields.
  localparam int RC8EN  = 0;
  localparam int RC8STB = 1;
  localparam int HEN    = 16;
  localparam int HSTB   = 17;
  localparam int HBPS   = 18;
  localparam int MON_EN  = 19;
  localparam int PLL_ON  = 24;
  localparam int PLL_RDY = 25;
  // Configuration register zero fields.
  localparam int SW_REQ = 0;
  localparam int SCSS   = 2;
  localparam int COSEL  = 24;
  localparam int CODIV  = 28;
  localparam int PLL_FULL = 31;
  // Interrupt register: sticky flags, interrupt enables, then write-one clear bits.
  localparam int RC40F  = 0;
  localparam int LXF    = 1;
  localparam int RC48F  = 2;
  localparam int CKMF   = 7;
  localparam int RC40IE = 8;
  localparam int LXIE   = 9;
  localparam int CLR    = 16;
  // Enable, stable and option bits of the smaller registers.
  localparam int EN     = 0;
  localparam int STB    = 1;
  localparam int OPT    = 2;
  // System clock switch codes.
  localparam logic [1:0] SW_RC8 = 2'h0;
  localparam logic [1:0] SW_HX  = 2'h1;
  localparam logic [1:0] SW_PLL = 2'h2;
  // Reference input codes of the phase locked loop.
  localparam logic [1:0] PS_RC8  = 2'h0;
  localparam logic [1:0] PS_HX   = 2'h1;
  localparam logic [1:0] PS_RC48 = 2'h2;
  // Clock output source codes.
  localparam logic [2:0] CO_RC28 = 3'h1;
  localparam logic [2:0] CO_RC40 = 3'h2;
  localparam logic [2:0] CO_LX   = 3'h3;
  localparam logic [2:0] CO_SYS  = 3'h4;
  localparam logic [2:0] CO_RC8  = 3'h5;
  localparam logic [2:0] CO_HX   = 3'h6;
  localparam logic [2:0] CO_PLL  = 3'h7;
  // Unlock key of the deep-sleep voltage register.
  localparam logic [31:0] VKEY_VAL = 32'h1A2B3C4D;
  // Crystal monitor stuck timeout in cycles.
  localparam int CKM_TIMEOUT_CYC = 64;
endpackage

// ### osc_ctrl_properties.sv
// Purpose: Port level checks of the oscillator control block.
// Assumes: One clock domain with an asynchronous active-low reset.
// Notes:   Attached by the bind below the module.
`timescale 1ns/100ps
module osc_ctrl_chk (
  input  wire logic       clk_in,
  input  wire logic       reset_n_in,
  input  wire logic       avs_read_in,
  input  wire logic       avs_write_in,
  input  wire logic       avs_waitrequest_out,
  input  wire logic       hx_ready_in,
  input  wire logic       deep_sleep_in,
  input  wire logic       cec_rc8_req_in,
  input  wire logic       rc8_on_out,
  input  wire logic       hx_on_out,
  input  wire logic       pll_on_out,
  input  wire logic       lx_on_out,
  input  wire logic       lx_clk_out,
  input  wire logic [1:0] sysclk_sel_out,
  input  wire logic       nmi_out,
  input  wire logic [1:0] dsv_out
);
  // Every check runs on the one clock and rests while reset is held.
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  a_bus_one_wait: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
    |=> !avs_waitrequest_out) else $error("bus answer late");
  a_reset_sys_rc8: assert property ($rose(reset_n_in) |-> sysclk_sel_out == osc_pkg::SW_RC8
    && rc8_on_out) else $error("reset source wrong");
  a_switch_when_stable: assert property ($changed(sysclk_sel_out)
    && sysclk_sel_out == osc_pkg::SW_HX |-> $past(hx_ready_in)) else $error("early switch");
  a_hx_in_use: assert property (sysclk_sel_out == osc_pkg::SW_HX |-> hx_on_out)
    else $error("crystal stopped in use");
  a_pll_in_use: assert property (sysclk_sel_out == osc_pkg::SW_PLL |-> pll_on_out)
    else $error("pll stopped in use");
  a_nmi_one_pulse: assert property (nmi_out |=> !nmi_out) else $error("nmi too long");
  a_fail_to_rc8: assert property (nmi_out |-> !hx_on_out && rc8_on_out
    && sysclk_sel_out != osc_pkg::SW_HX) else $error("failure not handled");
  a_lx_clock_gate: assert property (!lx_on_out |-> !lx_clk_out) else $error("lx clock leaks");
  a_dsv_by_write: assert property ($changed(dsv_out) |-> $past(avs_write_in))
    else $error("voltage changed without write");
  a_sleep_rc8_req: assert property (deep_sleep_in && cec_rc8_req_in |-> rc8_on_out)
    else $error("rc8 request ignored");
endmodule
bind osc_ctrl osc_ctrl_chk u_osc_ctrl_chk (.clk_in, .reset_n_in, .avs_read_in, .avs_write_in,
  .avs_waitrequest_out, .hx_ready_in, .deep_sleep_in, .cec_rc8_req_in, .rc8_on_out, .hx_on_out,
  .pll_on_out, .lx_on_out, .lx_clk_out, .sysclk_sel_out, .nmi_out, .dsv_out);

// ### tb_osc_ctrl.sv
// Purpose: Self-checking bench of the oscillator control block.
// Assumes: Monitor timeout shortened to 4 cycles.
// Notes:   Oscillator inputs are square waves from one free counter.
`timescale 1ns/100ps
module tb_osc_ctrl;
  logic        clk_in, reset_n_in, avs_read_in, avs_write_in, rc8_ready_in, hx_ready_in;
  logic [4:0]  avs_address_in;
  logic [31:0] avs_writedata_in, avs_readdata_out, k, seed = 32'h2C931412;
  logic [3:0]  avs_byteenable_in;
  logic [2:0]  rdy;
  logic [1:0]  pll_src_in, sysclk_sel_out, dsv_out, dsv_e;
  logic [7:0]  ph;
  logic [63:0] q[$];
  logic [63:0] e;
  logic pll_lock_in, run_clk, lxpin, deep_sleep_in, standby_in, cec_lx_sel_in, usart_lx_sel_in;
  logic cec_wake_in, usart_wake_in, cec_rc8_req_in, usart_rc8_req_in, avs_waitrequest_out;
  logic rc8_on_out, hx_on_out, hx_bypass_out, pll_on_out, rc48_on_out, lx_on_out, rc40_on_out;
  logic lx_clk_out, clock_output_out, stb_irq_out, nmi_out, wake_out;
  int   bad_count, n_tests, cyc, n;
  int   ex[8] = '{0, 256, 128, 64, 32, 16, 8, 64};
  logic [4:0] ofs[3] = '{osc_pkg::ADDCTL_OFS, osc_pkg::BDCTL_OFS, osc_pkg::RSTSCK_OFS};
  wire  rc48_ready_in = rdy[0];
  wire  lx_ready_in = rdy[1];
  wire  rc40_ready_in = rdy[2];
  wire  clk_rc28_in = run_clk & ph[0];
  wire  clk_rc40_in = run_clk & ph[1];
  wire  clk_lx_osc_in = run_clk & ph[2];
  wire  clk_lx_pin_in = lxpin;
  wire  clk_sys_in = run_clk & ph[3];
  wire  clk_rc8_in = run_clk & ph[4];
  wire  clk_hx_in = run_clk & ph[5];
  wire  clk_pll_in = run_clk & ph[1];

  osc_ctrl #(.CKM_TIMEOUT(4)) u_osc_ctrl (.clk_in, .reset_n_in, .avs_address_in, .avs_read_in,
    .avs_write_in, .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out,
    .rc8_ready_in, .hx_ready_in, .pll_lock_in, .rc48_ready_in, .lx_ready_in, .rc40_ready_in,
    .pll_src_in, .clk_rc28_in, .clk_rc40_in, .clk_lx_osc_in, .clk_lx_pin_in, .clk_rc8_in,
    .clk_hx_in, .clk_pll_in, .clk_sys_in, .deep_sleep_in, .standby_in, .cec_lx_sel_in,
    .usart_lx_sel_in, .cec_wake_in, .usart_wake_in, .cec_rc8_req_in, .usart_rc8_req_in,
    .rc8_on_out, .hx_on_out, .hx_bypass_out, .pll_on_out, .rc48_on_out, .lx_on_out, .rc40_on_out,
    .lx_clk_out, .sysclk_sel_out, .clock_output_out, .stb_irq_out, .nmi_out, .wake_out, .dsv_out);

  // Free clock of 10 ns period.
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  // Phase counter for the oscillators and a cycle limit against hangs.
  always @(posedge clk_in) begin
    ph <= ph + 8'h01;
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      bad_count++;
      close_out();
    end
  end

  // Takes the oldest read note off the queue when a read is answered.
  always @(posedge clk_in) begin
    if (avs_read_in === 1'b1 && avs_waitrequest_out === 1'b0 && q.size() > 0) begin
      e = q.pop_front();
      chk(avs_readdata_out & e[31:0], e[63:32]);
    end
  end

  task automatic close_out();
    if (bad_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One Avalon cycle held until waitrequest is seen low, then one idle cycle.
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= wr;
    avs_read_in <= !wr;
    do begin
      @(posedge clk_in);
    end while (avs_waitrequest_out !== 1'b0);
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] x, input logic [31:0] m);
    q.push_back({x, m});
    bus(1'b0, a, 32'h0);
  endtask

  task automatic tick(input int t);
    repeat (t) @(posedge clk_in);
  endtask

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Counts output rises over 512 cycles after a settling time.
  task automatic meas(input logic [31:0] cfg, input int x);
    int c = 0;
    logic p = 1'b0;
    wr(osc_pkg::CFG0_OFS, cfg);
    tick(300);
    repeat (512) begin
      @(posedge clk_in);
      if (clock_output_out === 1'b1 && p === 1'b0) c++;
      p = clock_output_out;
    end
    chk(32'(c >= x - 1 && c <= x + 1), 32'h1);
  endtask

  // Main sequence.
  initial begin
    {avs_read_in, avs_write_in, avs_address_in, avs_writedata_in, rdy, ph, lxpin} = '0;
    {hx_ready_in, pll_lock_in, run_clk, deep_sleep_in, standby_in, pll_src_in, dsv_e} = '0;
    {cec_lx_sel_in, usart_lx_sel_in, cec_wake_in, usart_wake_in} = '0;
    {cec_rc8_req_in, usart_rc8_req_in, bad_count, n_tests, cyc} = '0;
    avs_byteenable_in = 4'hF;
    rc8_ready_in = 1'b1;
    reset_n_in = 1'b0;
    tick(16);
    reset_n_in <= 1'b1;
    tick(1);
    chk(32'(sysclk_sel_out), 32'h0);
    rd(osc_pkg::CTL0_OFS, 32'h3, 32'h3);
    wr(osc_pkg::INT_OFS, 32'h300);
    for (int i = 0; i < 3; i++) begin
      wr(ofs[i], (i == 0) ? 32'h5 : 32'h1);
      chk(32'({stb_irq_out, rc48_on_out, lx_on_out, rc40_on_out}), 32'h4 >> i);
      rdy[i] <= 1'b1;
      tick(3);
      rd(ofs[i], 32'h3, 32'h3);
      rd(osc_pkg::INT_OFS, 32'h1 << (2 - i), 32'h7);
      chk(32'(stb_irq_out), 32'h1);
      wr(osc_pkg::INT_OFS, 32'h300 | (32'h1 << (18 - i)));
      wr(ofs[i], 32'h0);
      chk(32'({stb_irq_out, rc48_on_out, lx_on_out, rc40_on_out}), 32'h0);
    end
    lxpin <= 1'b1;
    wr(osc_pkg::BDCTL_OFS, 32'h5);
    chk(32'(lx_clk_out), 32'h1);
    wr(osc_pkg::BDCTL_OFS, 32'h1);
    chk(32'(lx_clk_out), 32'h0);
    wr(osc_pkg::CTL0_OFS, 32'h40001);
    wr(osc_pkg::CTL0_OFS, 32'h50001);
    wr(osc_pkg::CTL0_OFS, 32'h10001);
    chk(32'(hx_bypass_out), 32'h1);
    wr(osc_pkg::CFG0_OFS, 32'h1);
    tick(4);
    chk(32'(sysclk_sel_out), 32'h0);
    hx_ready_in <= 1'b1;
    tick(4);
    rd(osc_pkg::CFG0_OFS, 32'h5, 32'hF);
    wr(osc_pkg::CTL0_OFS, 32'h0);
    rd(osc_pkg::CTL0_OFS, 32'h10000, 32'h10001);
    wr(osc_pkg::CTL0_OFS, 32'hD0000);
    chk(32'(rc8_on_out), 32'h1);
    n = 0;
    while (nmi_out !== 1'b1 && n < 40) begin
      tick(1);
      n++;
    end
    tick(2);
    chk(32'({hx_on_out, sysclk_sel_out}), 32'h0);
    rd(osc_pkg::INT_OFS, 32'h80, 32'h80);
    wr(osc_pkg::CTL0_OFS, 32'h10001);
    wr(osc_pkg::CFG0_OFS, 32'h1);
    tick(4);
    chk(32'(sysclk_sel_out), 32'h0);
    wr(osc_pkg::INT_OFS, 32'h800300);
    tick(4);
    chk(32'(sysclk_sel_out), 32'h1);
    wr(osc_pkg::CFG0_OFS, 32'h0);
    wr(osc_pkg::CTL0_OFS, 32'h1010001);
    pll_lock_in <= 1'b1;
    tick(2);
    rd(osc_pkg::CTL0_OFS, 32'h2000000, 32'h2000000);
    run_clk <= 1'b1;
    for (int s = 0; s < 8; s++) meas(32'(s) << 24, ex[s]);
    meas(32'h87000000, 128);
    for (int d = 0; d < 8; d++) meas((32'(d) << 28) | 32'h1000000, 256 >> d);
    run_clk <= 1'b0;
    wr(osc_pkg::CFG0_OFS, 32'h2);
    tick(4);
    pll_src_in <= 2'h2;
    wr(osc_pkg::CTL0_OFS, 32'h10000);
    chk(32'({pll_on_out, sysclk_sel_out, rc8_on_out}), 32'hC);
    {deep_sleep_in, cec_rc8_req_in, cec_lx_sel_in, cec_wake_in, usart_wake_in} <= 5'h1F;
    tick(3);
    chk(32'({pll_on_out, hx_on_out, sysclk_sel_out}), 32'h0);
    chk(32'({rc8_on_out, wake_out}), 32'h3);
    {cec_lx_sel_in, cec_rc8_req_in} <= 2'h0;
    tick(2);
    chk(32'({rc8_on_out, wake_out}), 32'h0);
    deep_sleep_in <= 1'b0;
    for (int v = 0; v < 4; v++) begin
      k = xs();
      if (k == osc_pkg::VKEY_VAL) k = ~k;
      wr(osc_pkg::VKEY_OFS, k);
      wr(osc_pkg::DSV_OFS, 32'(3 - v));
      chk(32'(dsv_out), 32'(dsv_e));
      wr(osc_pkg::VKEY_OFS, osc_pkg::VKEY_VAL);
      wr(osc_pkg::DSV_OFS, 32'(v));
      chk(32'(dsv_out), 32'(v));
      dsv_e = 2'(v);
    end
    rd(osc_pkg::VKEY_OFS, 32'h0, 32'hFFFFFFFF);
    close_out();
  end
endmodule
